// ### src/sram_pkg.sv
// shared constants for the pipelined burst sram and its controller
package sram_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 18;
  localparam int LANES = 2;
  localparam int LANE_W = 9;
  localparam int BURST_W = 2;
  localparam int DEPTH = 65536;
  // timing and fifo sizes
  localparam int CLK_PERIOD_NS = 4;
  localparam int SLEEP_RECOVERY_TIME_NS = 8;
  localparam int SLEEP_RECOVERY_CYC = (SLEEP_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_PIPE = 3;
  localparam int FIFO_DEPTH = 32;
  localparam int CMD_W = 1 + ADDR_W + DATA_W + LANES;
  // burst order strap level, counter step and idle bus levels
  localparam logic ORDER_LINEAR = 1'b0;
  localparam logic [BURST_W-1:0] BEAT_ONE = 2'h1;
  localparam logic [LANES-1:0] LANES_NONE_N = 2'h3;
  localparam logic [DATA_W-1:0] BUS_IDLE = 18'h3FFFF;
endpackage : sram_pkg

// ### src/sram_bus_if.sv
// memory bus between the controller and the burst sram
`timescale 1ns/100ps
`default_nettype none
interface sram_bus_if;
  logic [sram_pkg::ADDR_W-1:0] addr;
  logic proc_addr_strobe_n;
  logic ctrl_addr_strobe_n;
  logic burst_advance_n;
  logic global_write_n;
  logic byte_write_en_n;
  logic [sram_pkg::LANES-1:0] byte_lane_sel_n;
  logic chip_sel_primary_n;
  logic chip_sel_expand_hi;
  logic chip_sel_expand_n;
  logic out_en_n;
  logic sleep_request;
  logic [sram_pkg::DATA_W-1:0] dq_ctrl;
  logic dq_ctrl_oe_n;
  logic [sram_pkg::DATA_W-1:0] dq_dev;
  logic dq_dev_oe_n;
  logic [sram_pkg::DATA_W-1:0] dq;

  // resolved shared data wire, idles high
  assign dq = !dq_dev_oe_n ? dq_dev : (!dq_ctrl_oe_n ? dq_ctrl : sram_pkg::BUS_IDLE);

  modport device (
    input addr, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, global_write_n,
    input byte_write_en_n, byte_lane_sel_n, chip_sel_primary_n, chip_sel_expand_hi,
    input chip_sel_expand_n, out_en_n, sleep_request, dq,
    output dq_dev, dq_dev_oe_n
  );
  modport ctrl (
    output addr, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, global_write_n,
    output byte_write_en_n, byte_lane_sel_n, chip_sel_primary_n, chip_sel_expand_hi,
    output chip_sel_expand_n, out_en_n, sleep_request, dq_ctrl, dq_ctrl_oe_n,
    input dq
  );
endinterface : sram_bus_if
`default_nettype wire

// ### src/sram_device.sv
// pipelined burst sram end: array, burst counter, output pipeline, sleep
//
// Behaviour
// R01: read starts on strobe, selected, no write
// R02: capture address, data out next edge
// R03: first cycle after selection stays three-stated
// R04: deselect three-states outputs at once
// R05: back-to-back single reads supported
// R06: processor strobe write takes two cycles
// R07: global write stores all bytes
// R08: byte write stores only selected lanes
// R09: controller strobe write completes in one cycle
// R10: advance ignored on controller address load
// R11: write cycle forces data drivers off
// R12: controller raises output enable before write data
// R13: two-bit wraparound burst counter, order strap
// R14: interleaved order xors start with beat
// R15: linear order counts up modulo four
// R16: advance low steps burst counter
// R17: async sleep, two cycles, outputs off
// R18: controller deselects before raising sleep
// R19: controller idles two cycles after sleep
// R20: strobes high: advance continues, else holds
// R21: processor strobe cycle always starts read
// R22: output enable acts combinationally, write-masked
`timescale 1ns/100ps
`default_nettype none
module sram_device #(
  parameter int ADDR_W = sram_pkg::ADDR_W,
  parameter int DEPTH = sram_pkg::DEPTH
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // burst order strap, high or open selects interleaved
  input wire logic burst_order_in,
  // memory bus
  sram_bus_if.device bus,
  // status
  output logic asleep_out
);
  localparam int BW = sram_pkg::BURST_W;
  localparam int LW = sram_pkg::LANE_W;
  localparam int NL = sram_pkg::LANES;

  // low address bits of a burst beat in the chosen order
  function automatic logic [BW-1:0] burst_low(input logic [BW-1:0] start, input logic [BW-1:0] beat,
                                              input logic interleave);
    logic [BW-1:0] r;
    r = interleave ? (start ^ beat) : BW'(start + beat); // R14 R15
    return r;
  endfunction : burst_low

  // lane write enables from the write controls
  function automatic logic [NL-1:0] lane_we(input logic gw_n, input logic bwe_n,
                                            input logic [NL-1:0] sel_n);
    logic [NL-1:0] r;
    if (!gw_n) begin
      r = '1; // R07
    end else if (!bwe_n) begin
      r = ~sel_n; // R08
    end else begin
      r = '0;
    end
    return r;
  endfunction : lane_we

  // synchronisers for the asynchronous sleep pin and the strap
  logic sleep_meta_q;
  logic sleep_q;
  logic order_meta_q;
  logic order_q;

  // access state
  logic active_q, active_d;
  logic [ADDR_W-BW-1:0] base_q, base_d;
  logic [BW-1:0] start_q, start_d;
  logic [BW-1:0] beat_q, beat_d;
  logic rd_pend_q, rd_pend_d;
  logic [ADDR_W-1:0] rd_addr_q, rd_addr_d;
  logic rd_valid_q, rd_valid_d;
  logic [sram_pkg::DATA_W-1:0] dout_q, dout_d;

  // array write port
  logic [NL-1:0] we;
  logic [ADDR_W-1:0] wr_addr;
  logic [sram_pkg::DATA_W-1:0] rd_word;

  // decoded bus conditions
  logic all_sel;
  logic proc_start;
  logic ctrl_start;
  logic deselect;
  logic [NL-1:0] wr_lanes;
  logic wr_req;
  logic wr_cycle;
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-1:0] next_addr;

  // two flops before anything reads the pins
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sleep_meta_q <= 1'b0;
      sleep_q <= 1'b0;
      order_meta_q <= 1'b1;
      order_q <= 1'b1;
    end else begin
      sleep_meta_q <= bus.sleep_request; // R17
      sleep_q <= sleep_meta_q;
      order_meta_q <= burst_order_in;
      order_q <= order_meta_q;
    end
  end

  // strobe and select decode
  always_comb begin
    all_sel = !bus.chip_sel_primary_n && bus.chip_sel_expand_hi && !bus.chip_sel_expand_n;
    proc_start = !bus.proc_addr_strobe_n && !bus.chip_sel_primary_n; // R01
    ctrl_start = !proc_start && !bus.ctrl_addr_strobe_n;
    deselect = (proc_start || ctrl_start) && !all_sel;
    wr_lanes = lane_we(bus.global_write_n, bus.byte_write_en_n, bus.byte_lane_sel_n);
    wr_req = |wr_lanes;
    cur_addr = {base_q, burst_low(start_q, beat_q, order_q != sram_pkg::ORDER_LINEAR)};
    next_addr = {base_q, burst_low(start_q, BW'(beat_q + sram_pkg::BEAT_ONE),
                                   order_q != sram_pkg::ORDER_LINEAR)}; // R13
    // processor strobe cycles never write
    wr_cycle = !sleep_q && wr_req && !proc_start && !deselect
               && (ctrl_start || active_q); // R21
  end

  // next access state
  always_comb begin
    active_d = active_q;
    base_d = base_q;
    start_d = start_q;
    beat_d = beat_q;
    rd_pend_d = 1'b0;
    rd_addr_d = rd_addr_q;
    rd_valid_d = rd_pend_q; // R02 R05
    we = '0;
    wr_addr = cur_addr;
    if (sleep_q) begin
      active_d = 1'b0; // R17
      rd_valid_d = 1'b0;
    end else if (deselect) begin
      active_d = 1'b0;
      rd_valid_d = 1'b0; // R04
    end else if (proc_start || ctrl_start) begin
      // external address into register and counter, advance ignored
      active_d = 1'b1;
      base_d = bus.addr[ADDR_W-1:BW];
      start_d = bus.addr[BW-1:0]; // R13 R10
      beat_d = '0;
      if (ctrl_start && wr_req) begin
        we = wr_lanes; // R09
        wr_addr = bus.addr;
        rd_valid_d = 1'b0; // R11
      end else begin
        // first cycle of processor strobe access is a read
        rd_pend_d = 1'b1; // R01 R21 R06
        rd_addr_d = bus.addr;
        rd_valid_d = rd_pend_q && active_q; // R03
      end
    end else if (active_q) begin
      // both strobes high: continue or suspend the burst
      if (!bus.burst_advance_n) begin
        beat_d = BW'(beat_q + sram_pkg::BEAT_ONE); // R16 R20
        wr_addr = next_addr;
      end
      if (wr_req) begin
        we = wr_lanes; // R06 R07 R08
        rd_valid_d = 1'b0; // R11
      end else begin
        rd_pend_d = 1'b1; // R20
        rd_addr_d = bus.burst_advance_n ? cur_addr : next_addr;
      end
    end
  end

  // array read feeds the output register
  always_comb begin
    dout_d = rd_word;
  end

  // access state registers
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      active_q <= 1'b0;
      base_q <= '0;
      start_q <= '0;
      beat_q <= '0;
      rd_pend_q <= 1'b0;
      rd_addr_q <= '0;
      rd_valid_q <= 1'b0;
      dout_q <= '0;
    end else begin
      active_q <= active_d;
      base_q <= base_d;
      start_q <= start_d;
      beat_q <= beat_d;
      rd_pend_q <= rd_pend_d;
      rd_addr_q <= rd_addr_d;
      rd_valid_q <= rd_valid_d;
      dout_q <= dout_d;
    end
  end

  // one storage array per byte lane, contents kept through sleep
  for (genvar l = 0; l < NL; l++) begin : g_lane
    logic [LW-1:0] mem [DEPTH];
    always_ff @(posedge clock_in) begin
      if (we[l] && !sleep_q) begin
        mem[wr_addr] <= bus.dq[l*LW +: LW]; // R08
      end
    end
    assign rd_word[l*LW +: LW] = mem[rd_addr_q];
  end

  // output enable is not clocked and is masked during writes
  assign bus.dq_dev = dout_q;
  assign bus.dq_dev_oe_n = !(rd_valid_q && !bus.out_en_n && !sleep_q && !wr_cycle); // R22 R11 R17
  assign asleep_out = sleep_q;
endmodule : sram_device
`default_nettype wire

// ### src/sram_controller.sv
// controller end: command fifo and sram bus sequencer
`timescale 1ns/100ps
`default_nettype none
module cmd_fifo #(
  parameter int WIDTH = sram_pkg::CMD_W,
  parameter int DEPTH = sram_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wp_q, wp_d, rp_q, rp_d;
  logic push, pop;

  // pointer update, one extra bit tells full from empty
  always_comb begin
    in_ready_out = (wp_q - rp_q) != (PW+1)'(DEPTH);
    out_valid_out = wp_q != rp_q;
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    wp_d = push ? (PW+1)'(wp_q + 1'b1) : wp_q;
    rp_d = pop ? (PW+1)'(rp_q + 1'b1) : rp_q;
    out_data_out = mem[rp_q[PW-1:0]];
  end

  // pointers
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  // storage
  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[wp_q[PW-1:0]] <= in_data_in;
    end
  end
endmodule : cmd_fifo

module sram_controller (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // command stream
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic cmd_write_in,
  input wire logic [sram_pkg::ADDR_W-1:0] cmd_addr_in,
  input wire logic [sram_pkg::DATA_W-1:0] cmd_wdata_in,
  input wire logic [sram_pkg::LANES-1:0] cmd_byte_en_in,
  // read data
  output logic rsp_valid_out,
  output logic [sram_pkg::DATA_W-1:0] rsp_data_out,
  // sleep control
  input wire logic sleep_in,
  output logic asleep_out,
  // memory bus
  sram_bus_if.ctrl bus
);
  localparam int AW = sram_pkg::ADDR_W;
  localparam int DW = sram_pkg::DATA_W;
  localparam int NL = sram_pkg::LANES;

  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_PARK = 4'h2,
    ST_SLEEP = 4'h4,
    ST_WAKE = 4'h8
  } state_t;

  state_t state_q, state_d;
  logic f_valid, f_ready;
  logic [sram_pkg::CMD_W-1:0] f_data;
  logic f_write;
  logic [AW-1:0] f_addr;
  logic [DW-1:0] f_wdata;
  logic [NL-1:0] f_be;
  logic [sram_pkg::RD_PIPE-1:0] pipe_q, pipe_d;
  logic [1:0] wait_q, wait_d;
  logic strobe_q, strobe_d, ce_q, ce_d, oe_n_q, oe_n_d, wr_q, wr_d, sleep_q, sleep_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [DW-1:0] wdata_q, wdata_d;
  logic [NL-1:0] sel_n_q, sel_n_d;
  logic rsp_valid_q, rsp_valid_d;
  logic [DW-1:0] rsp_data_q, rsp_data_d;
  logic issue_rd, issue_wr;

  cmd_fifo #(.WIDTH(sram_pkg::CMD_W), .DEPTH(sram_pkg::FIFO_DEPTH)) u_fifo (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .in_valid_in(cmd_valid_in),
    .in_ready_out(cmd_ready_out),
    .in_data_in({cmd_write_in, cmd_addr_in, cmd_wdata_in, cmd_byte_en_in}),
    .out_valid_out(f_valid),
    .out_ready_in(f_ready),
    .out_data_out(f_data)
  );

  // sequencer: one bus cycle per command, turnaround before writes
  always_comb begin
    {f_write, f_addr, f_wdata, f_be} = f_data;
    state_d = state_q;
    wait_d = wait_q;
    sleep_d = sleep_q;
    strobe_d = 1'b0;
    ce_d = 1'b0;
    wr_d = 1'b0;
    addr_d = addr_q;
    wdata_d = wdata_q;
    sel_n_d = sel_n_q;
    issue_rd = 1'b0;
    issue_wr = 1'b0;
    case (state_q)
      ST_RUN: begin
        if (sleep_in && pipe_q == '0) begin
          state_d = ST_PARK;
        end else if (f_valid && !sleep_in) begin
          issue_wr = f_write && pipe_q == '0 && oe_n_q; // R12
          issue_rd = !f_write;
        end
      end
      ST_PARK: begin
        strobe_d = 1'b1; // R18
        state_d = ST_SLEEP;
      end
      ST_SLEEP: begin
        sleep_d = sleep_in;
        if (!sleep_in) begin
          wait_d = 2'(sram_pkg::SLEEP_RECOVERY_CYC);
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        wait_d = wait_q - 1'b1; // R19
        if (wait_q == 2'h1) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
    if (issue_rd || issue_wr) begin
      strobe_d = 1'b1; // R09
      ce_d = 1'b1;
      wr_d = issue_wr;
      addr_d = f_addr;
      wdata_d = f_wdata;
      sel_n_d = issue_wr ? ~f_be : sram_pkg::LANES_NONE_N;
    end
    f_ready = issue_rd || issue_wr;
    pipe_d = {pipe_q[sram_pkg::RD_PIPE-2:0], issue_rd};
    oe_n_d = !(issue_rd || |pipe_q[sram_pkg::RD_PIPE-2:0]);
    rsp_valid_d = pipe_q[sram_pkg::RD_PIPE-1];
    rsp_data_d = pipe_q[sram_pkg::RD_PIPE-1] ? bus.dq : rsp_data_q;
  end

  // sequencer registers
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= ST_RUN;
      wait_q <= '0;
      sleep_q <= 1'b0;
      strobe_q <= 1'b0;
      ce_q <= 1'b0;
      wr_q <= 1'b0;
      oe_n_q <= 1'b1;
      addr_q <= '0;
      wdata_q <= '0;
      sel_n_q <= sram_pkg::LANES_NONE_N;
      pipe_q <= '0;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= '0;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      sleep_q <= sleep_d;
      strobe_q <= strobe_d;
      ce_q <= ce_d;
      wr_q <= wr_d;
      oe_n_q <= oe_n_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      sel_n_q <= sel_n_d;
      pipe_q <= pipe_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q <= rsp_data_d;
    end
  end

  // pins from flops or tied to constants; park cycle deselects with primary select high
  assign bus.addr = addr_q;
  assign bus.proc_addr_strobe_n = 1'b1;
  assign bus.ctrl_addr_strobe_n = !strobe_q;
  assign bus.burst_advance_n = 1'b1;
  assign bus.global_write_n = 1'b1;
  assign bus.byte_write_en_n = !wr_q;
  assign bus.byte_lane_sel_n = sel_n_q;
  assign bus.chip_sel_primary_n = !ce_q;
  assign bus.chip_sel_expand_hi = 1'b1;
  assign bus.chip_sel_expand_n = 1'b0;
  assign bus.out_en_n = oe_n_q;
  assign bus.sleep_request = sleep_q;
  assign bus.dq_ctrl = wdata_q;
  assign bus.dq_ctrl_oe_n = !wr_q;
  assign rsp_valid_out = rsp_valid_q;
  assign rsp_data_out = rsp_data_q;
  assign asleep_out = sleep_q;
endmodule : sram_controller
`default_nettype wire

// ### verif/sram_bus_monitor.sv
// concurrent checks on the memory bus between controller and burst sram
`timescale 1ns/100ps
`default_nettype none
module sram_bus_monitor (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // bus controls
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic global_write_n,
  input wire logic byte_write_en_n,
  input wire logic [sram_pkg::LANES-1:0] byte_lane_sel_n,
  input wire logic chip_sel_primary_n,
  input wire logic out_en_n,
  input wire logic sleep_request,
  // data drive enables
  input wire logic dq_ctrl_oe_n,
  input wire logic dq_dev_oe_n
);
  logic wr_c;
  logic sel_c;
  logic desel_c;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_b_in);

  // decoded bus cycle kinds
  assign wr_c = !global_write_n || (!byte_write_en_n && byte_lane_sel_n != sram_pkg::LANES_NONE_N);
  assign sel_c = !ctrl_addr_strobe_n && proc_addr_strobe_n && !chip_sel_primary_n;
  assign desel_c = !ctrl_addr_strobe_n && chip_sel_primary_n;

  AST_WRITE_MASKS_DRIVE: assert property (proc_addr_strobe_n && wr_c |-> dq_dev_oe_n)
    else $error("device drives data during a write cycle");
  AST_OE_GATES_DRIVE: assert property (out_en_n |-> dq_dev_oe_n)
    else $error("device drives data with output enable high");
  AST_DESELECT_OFF: assert property (desel_c |=> dq_dev_oe_n)
    else $error("device drives data after deselect");
  AST_READ_DRIVES: assert property (
    sel_c && !wr_c ##1 !desel_c ##1 (!out_en_n && !wr_c && !sleep_request) |-> !dq_dev_oe_n)
    else $error("read data not driven two cycles after capture");
  AST_SLEEP_OFF: assert property (sleep_request [*3] |-> dq_dev_oe_n)
    else $error("device drives data while asleep");
  AST_SLEEP_DESELECTED: assert property ($rose(sleep_request) |-> $past(chip_sel_primary_n))
    else $error("sleep raised while selected");
  AST_SLEEP_RECOVERY: assert property (
    $fell(sleep_request) |-> (ctrl_addr_strobe_n && proc_addr_strobe_n && chip_sel_primary_n) [*2])
    else $error("access started during sleep recovery");
  AST_WRITE_AFTER_OE: assert property (!dq_ctrl_oe_n |-> out_en_n && $past(out_en_n))
    else $error("write data driven without output enable high first");
  AST_WRITE_DATA_SAME_EDGE: assert property (sel_c && wr_c |-> !dq_ctrl_oe_n)
    else $error("controller strobe write without data on the bus");
  AST_READ_NO_CTRL_DATA: assert property (sel_c && !wr_c |-> dq_ctrl_oe_n)
    else $error("controller drives data during a read start");
endmodule : sram_bus_monitor
`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench: controller and burst sram joined over the memory bus
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic burst_order_in = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [sram_pkg::ADDR_W-1:0] cmd_addr = 16'h0000;
  logic [sram_pkg::DATA_W-1:0] cmd_wdata = 18'h00000;
  logic [sram_pkg::LANES-1:0] cmd_be = 2'h3;
  logic sleep_in = 1'b0;
  logic cmd_ready;
  logic rsp_valid;
  logic ctrl_asleep;
  logic dev_asleep;
  logic [sram_pkg::DATA_W-1:0] rsp_data;
  logic [sram_pkg::DATA_W-1:0] ref_mem [logic [15:0]];
  logic [sram_pkg::DATA_W-1:0] exp_q [$];
  logic [sram_pkg::ADDR_W-1:0] pool [16];
  logic [sram_pkg::DATA_W-1:0] dmem [4];
  int num_errors = 0;
  int checks = 0;

  sram_bus_if bus_if ();
  // second device driven straight from the bench for bursts and processor strobe cycles
  sram_bus_if dut_if ();

  sram_device sram_device_inst2 (.clock_in(clock_in), .rst_b_in(rst_b_in), .burst_order_in(burst_order_in),
    .bus(dut_if), .asleep_out());

  sram_device sram_device_inst (.clock_in(clock_in), .rst_b_in(rst_b_in), .burst_order_in(burst_order_in),
    .bus(bus_if), .asleep_out(dev_asleep));

  sram_controller sram_controller_inst (.clock_in(clock_in), .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid),
    .cmd_ready_out(cmd_ready), .cmd_write_in(cmd_write), .cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata),
    .cmd_byte_en_in(cmd_be), .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data), .sleep_in(sleep_in),
    .asleep_out(ctrl_asleep), .bus(bus_if));

  sram_bus_monitor sram_bus_monitor_inst (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .proc_addr_strobe_n(bus_if.proc_addr_strobe_n), .ctrl_addr_strobe_n(bus_if.ctrl_addr_strobe_n),
    .global_write_n(bus_if.global_write_n), .byte_write_en_n(bus_if.byte_write_en_n),
    .byte_lane_sel_n(bus_if.byte_lane_sel_n), .chip_sel_primary_n(bus_if.chip_sel_primary_n),
    .out_en_n(bus_if.out_en_n), .sleep_request(bus_if.sleep_request),
    .dq_ctrl_oe_n(bus_if.dq_ctrl_oe_n), .dq_dev_oe_n(bus_if.dq_dev_oe_n));

  // free-running clock
  initial begin
    forever #2 clock_in = ~clock_in;
  end

  task automatic end_of_test();
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask : check

  // expected word after a lane-selective write
  function automatic logic [17:0] merge(input logic [17:0] old, input logic [17:0] d, input logic [1:0] be);
    merge = old;
    if (be[0]) merge[8:0] = d[8:0];
    if (be[1]) merge[17:9] = d[17:9];
  endfunction : merge

  // low address bits of burst beat k: interleaved when the strap is high, else linear
  function automatic logic [1:0] beat(input logic [1:0] s, input int k, input logic order);
    beat = order ? (s ^ 2'(k)) : 2'(s + 2'(k));
  endfunction : beat

  // one cycle on the direct device bus, write data driven whenever a write control is low
  task automatic dcyc(input logic ps_n, input logic cs_n, input logic ce_n, input logic gw_n,
                      input logic bwe_n, input logic [1:0] sel_n, input logic adv_n, input logic oe_n,
                      input logic [15:0] a, input logic [17:0] d);
    dut_if.proc_addr_strobe_n <= ps_n;
    dut_if.ctrl_addr_strobe_n <= cs_n;
    dut_if.chip_sel_primary_n <= ce_n;
    dut_if.global_write_n <= gw_n;
    dut_if.byte_write_en_n <= bwe_n;
    dut_if.byte_lane_sel_n <= sel_n;
    dut_if.burst_advance_n <= adv_n;
    dut_if.out_en_n <= oe_n;
    dut_if.addr <= a;
    dut_if.dq_ctrl <= d;
    dut_if.dq_ctrl_oe_n <= gw_n && bwe_n;
    @(posedge clock_in);
  endtask : dcyc

  // present one command and hold it until taken or the limit runs out
  task automatic send(input logic wr, input logic [15:0] a, input logic [17:0] d, input logic [1:0] be,
                      input int limit, output bit taken);
    int n;
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_be <= be;
    taken = 1'b0;
    n = 0;
    while (!taken && n < limit) begin
      @(posedge clock_in);
      n++;
      taken = (cmd_ready === 1'b1);
    end
    if (taken && wr) ref_mem[a] = merge(ref_mem.exists(a) ? ref_mem[a] : 18'h00000, d, be);
    else if (taken) exp_q.push_back(ref_mem[a]);
    else begin
      cmd_valid <= 1'b0;
      if (limit > 1) check(32'(taken), 32'h1);
    end
  endtask : send

  task automatic stop_cmd();
    cmd_valid <= 1'b0;
    @(posedge clock_in);
  endtask : stop_cmd

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 600) begin
      @(posedge clock_in);
      n++;
    end
    check(32'(exp_q.size()), 32'h0);
  endtask : drain

  // read responses compared in command order
  always @(posedge clock_in) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else check(32'(rsp_data), 32'(exp_q.pop_front()));
    end
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge clock_in);
    num_errors++;
    end_of_test();
  end

  initial begin
    int n;
    int accepted;
    bit ok;
    logic [15:0] base;
    logic [1:0] s;
    logic [17:0] d;
    void'($urandom(14024));
    burst_order_in <= 1'($urandom());
    dut_if.chip_sel_expand_hi <= 1'b1;
    dut_if.chip_sel_expand_n <= 1'b0;
    dut_if.sleep_request <= 1'b0;
    dcyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h3, 1'b1, 1'b1, 16'h0000, 18'h00000);
    repeat (2) @(posedge clock_in);
    rst_b_in <= 1'b1;
    // direct device bus: global writes, processor strobe byte write, burst read, deselect; both orders
    for (int p = 0; p < 2; p++) begin
      if (p == 1) burst_order_in <= !burst_order_in;
      base = {14'($urandom()), 2'h0};
      for (int k = 0; k < 4; k++) begin
        dmem[k] = 18'($urandom());
        dcyc(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 2'h3, 1'b0, 1'b1, {base[15:2], 2'(k)}, dmem[k]);
      end
      s = 2'($urandom());
      d = 18'($urandom());
      dcyc(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 2'h3, 1'b1, 1'b1, {base[15:2], s}, ~d);
      dcyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'h2, 1'b1, 1'b1, 16'h0000, d);
      dmem[s] = merge(dmem[s], d, 2'h1);
      dcyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 2'h3, 1'b1, 1'b0, {base[15:2], s}, 18'h00000);
      for (int k = 0; k < 6; k++) begin
        dcyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h3, (k > 2), 1'b0, 16'h0000, 18'h00000);
        if (k > 0) check(32'(dut_if.dq), 32'(dmem[beat(s, (k > 3) ? 3 : k - 1, burst_order_in)]));
      end
      dcyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 2'h3, 1'b1, 1'b0, 16'h0000, 18'h00000);
      dcyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h3, 1'b1, 1'b0, 16'h0000, 18'h00000);
      check(32'(dut_if.dq_dev_oe_n), 32'h1);
    end
    dcyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h3, 1'b1, 1'b1, 16'h0000, 18'h00000);
    // full writes, then single-lane writes over the same words
    for (int i = 0; i < 16; i++) begin
      pool[i] = {12'($urandom()), 4'(i)};
      send(1'b1, pool[i], 18'($urandom()), 2'h3, 50, ok);
    end
    for (int i = 0; i < 16; i++) begin
      send(1'b1, pool[i], 18'($urandom()), (i % 2) ? 2'h2 : 2'h1, 50, ok);
    end
    // back-to-back single reads
    for (int i = 0; i < 16; i++) begin
      send(1'b0, pool[i], 18'h00000, 2'h3, 50, ok);
    end
    stop_cmd();
    drain();
    // random mix of reads and lane writes
    for (int i = 0; i < 200; i++) begin
      send(1'($urandom()), pool[$urandom_range(15)], 18'($urandom()), 2'($urandom_range(3, 1)), 50, ok);
    end
    // closing read pulls every queued write out of the fifo before sleep
    send(1'b0, pool[0], 18'h00000, 2'h3, 50, ok);
    stop_cmd();
    drain();
    // sleep: fifo fills to refusal while commands wait
    sleep_in <= 1'b1;
    n = 0;
    while (dev_asleep !== 1'b1 && n < 50) begin
      @(posedge clock_in);
      n++;
    end
    check(32'(dev_asleep), 32'h1);
    check(32'(ctrl_asleep), 32'h1);
    accepted = 0;
    ok = 1'b1;
    while (ok && accepted < 40) begin
      send(1'b0, pool[accepted % 16], 18'h00000, 2'h3, 1, ok);
      if (ok) accepted++;
    end
    check(32'(accepted), 32'(sram_pkg::FIFO_DEPTH));
    sleep_in <= 1'b0;
    drain();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
